/* rtl/ebms_consts.vh */
// Constants for the external bus mode sequencer
`ifndef EBMS_CONSTS_VH
`define EBMS_CONSTS_VH
// Bus mode codes, one bit per chip select
`define EBMS_MODE_THREE 1'b0
`define EBMS_MODE_FOUR 1'b1
// Clocks-per-state bounds
`define EBMS_LEN_MIN_THREE 4'h1
`define EBMS_LEN_MIN_FOUR 4'h2
`define EBMS_LEN_MAX 4'hF
// Field width of one clocks-per-state entry
`define EBMS_LEN_W 4
// Reset values of the pin registers
`define EBMS_ADDR_RST 24'h000000
`define EBMS_DATA_RST 8'h00
`define EBMS_CS_RST 4'hF
`define EBMS_STROBE_RST 1'b1
`define EBMS_ALE_RST 1'b0
`endif

/* rtl/ebms_sequencer.v */
// External bus sequencer for three-state and four-state chip select modes
`timescale 1ns/100ps
`include "ebms_consts.vh"

module ebms_sequencer (
  input wire sys_clk,
  input wire rst_n,
  input wire req,
  input wire [1:0] req_cs,
  input wire req_write,
  input wire req_io,
  input wire [23:0] req_addr,
  input wire [7:0] req_wdata,
  input wire [3:0] cfg_mode,
  input wire [3:0] cfg_mux,
  input wire [15:0] cfg_clks,
  input wire wait_n,
  input wire [7:0] data_in,
  output reg [23:0] addr_q,
  output reg [7:0] data_out_q,
  output reg data_oe_q,
  output reg [3:0] cs_n_q,
  output reg rd_n_q,
  output reg wr_n_q,
  output reg memory_request_strobe_n_q,
  output reg io_request_strobe_n_q,
  output reg ale_q,
  output reg busy_q,
  output reg done_q,
  output reg [7:0] rdata_q
);

  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_T1 = 6'h02;
  localparam [5:0] ST_T2 = 6'h04;
  localparam [5:0] ST_TW = 6'h08;
  localparam [5:0] ST_T3 = 6'h10;
  localparam [5:0] ST_T4 = 6'h20;

  reg rst_meta_q;
  reg rst_sync_q;
  reg wait_meta_q;
  reg wait_sync_q;
  reg [7:0] din_meta_q;
  reg [7:0] din_sync_q;
  reg [5:0] state_q;
  reg four_q;
  reg mux_q;
  reg write_q;
  reg [3:0] len_q;
  reg [3:0] len_d;
  reg io_q;
  reg [7:0] wdata_q;
  wire start;
  wire last;
  wire [3:0] cnt;
  wire [3:0] sel_len;
  wire [3:0] half;

  // Reset release through two flops
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // Pin inputs synchronised; read data therefore reflects pins two clocks back
  always @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      wait_meta_q <= 1'b1;
      wait_sync_q <= 1'b1;
      din_meta_q <= 8'h00;
      din_sync_q <= 8'h00;
    end else begin
      wait_meta_q <= wait_n;
      wait_sync_q <= wait_meta_q;
      din_meta_q <= data_in;
      din_sync_q <= din_meta_q;
    end
  end

  // Per chip select state length, clamped to the mode's range
  assign sel_len = cfg_clks[{req_cs, 2'b00} +: `EBMS_LEN_W];
  always @* begin
    len_d = sel_len;
    if (cfg_mode[req_cs] == `EBMS_MODE_FOUR) begin
      if (sel_len < `EBMS_LEN_MIN_FOUR) begin
        len_d = `EBMS_LEN_MIN_FOUR;
      end
    end else if (sel_len < `EBMS_LEN_MIN_THREE) begin
      len_d = `EBMS_LEN_MIN_THREE;
    end
  end

  assign start = (state_q == ST_IDLE) && req;
  assign half = {1'b0, len_q[3:1]};

  ebms_state_timer u_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_sync_q),
    .start(start),
    .len(len_q),
    .cnt_q(cnt),
    .last(last)
  );

  // Bus state machine; pins change only at state boundaries or mid-T1
  always @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q <= ST_IDLE;
      four_q <= 1'b0;
      mux_q <= 1'b0;
      write_q <= 1'b0;
      len_q <= `EBMS_LEN_MIN_THREE;
      addr_q <= `EBMS_ADDR_RST;
      data_out_q <= `EBMS_DATA_RST;
      data_oe_q <= 1'b0;
      cs_n_q <= `EBMS_CS_RST;
      rd_n_q <= `EBMS_STROBE_RST;
      wr_n_q <= `EBMS_STROBE_RST;
      memory_request_strobe_n_q <= `EBMS_STROBE_RST;
      io_request_strobe_n_q <= `EBMS_STROBE_RST;
      ale_q <= `EBMS_ALE_RST;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (req) begin
            state_q <= ST_T1;
            busy_q <= 1'b1;
            four_q <= cfg_mode[req_cs];
            mux_q <= cfg_mux[req_cs] & cfg_mode[req_cs];
            write_q <= req_write;
            len_q <= len_d;
            addr_q <= req_addr;
            cs_n_q[req_cs] <= 1'b0;
            ale_q <= cfg_mode[req_cs];
            if (cfg_mode[req_cs] && cfg_mux[req_cs]) begin
              data_out_q <= req_addr[7:0];
              data_oe_q <= 1'b1;
            end else begin
              data_out_q <= req_wdata;
              data_oe_q <= req_write;
            end
          end
        end
        ST_T1: begin
          // Latch strobe falls halfway through T1
          if (four_q && (cnt == half - 4'h1)) begin
            ale_q <= 1'b0;
          end
          if (last) begin
            state_q <= ST_T2;
            rd_n_q <= write_q;
            wr_n_q <= ~write_q;
            memory_request_strobe_n_q <= req_io_q_n(1'b0);
            io_request_strobe_n_q <= req_io_q_n(1'b1);
            if (mux_q) begin
              data_out_q <= wdata_q;
              data_oe_q <= write_q;
            end
          end
        end
        ST_T2: begin
          // Ready is sampled once, at the last clock of T2
          if (last) begin
            state_q <= wait_sync_q ? ST_T3 : ST_TW;
          end
        end
        ST_TW: begin
          // Each wait state is one full state, nothing else moves
          if (last && wait_sync_q) begin
            state_q <= ST_T3;
          end
        end
        ST_T3: begin
          if (last) begin
            if (!write_q) begin
              rdata_q <= din_sync_q;
            end
            if (four_q) begin
              state_q <= ST_T4;
              rd_n_q <= 1'b1;
              wr_n_q <= 1'b1;
            end else begin
              state_q <= ST_IDLE;
              cs_n_q <= `EBMS_CS_RST;
              rd_n_q <= 1'b1;
              wr_n_q <= 1'b1;
              memory_request_strobe_n_q <= 1'b1;
              io_request_strobe_n_q <= 1'b1;
              data_oe_q <= 1'b0;
              busy_q <= 1'b0;
              done_q <= 1'b1;
            end
          end
        end
        ST_T4: begin
          // Address and data held to the end of T4
          if (last) begin
            state_q <= ST_IDLE;
            cs_n_q <= `EBMS_CS_RST;
            memory_request_strobe_n_q <= 1'b1;
            io_request_strobe_n_q <= 1'b1;
            data_oe_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Request type and write data kept for the whole cycle
  always @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      io_q <= 1'b0;
      wdata_q <= 8'h00;
    end else if (start) begin
      io_q <= req_io;
      wdata_q <= req_wdata;
    end
  end

  // Low for the strobe that matches the instruction type
  function req_io_q_n;
    input want_io;
    begin
      req_io_q_n = ~(io_q == want_io);
    end
  endfunction

endmodule // ebms_sequencer

/* rtl/ebms_state_timer.v */
// Per-state clock counter for the bus mode sequencer
`timescale 1ns/100ps
module ebms_state_timer (
  input wire sys_clk,
  input wire rst_n,
  input wire start,
  input wire [3:0] len,
  output reg [3:0] cnt_q,
  output wire last
);

  reg [3:0] cnt_d;

  // Last clock of the current state
  assign last = (cnt_q == (len - 4'h1));

  // Restart on a new cycle or at each state boundary
  always @* begin
    if (start || last) begin
      cnt_d = 4'h0;
    end else begin
      cnt_d = cnt_q + 4'h1;
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule // ebms_state_timer

/* verification/ebms_checker.sv */
// Port assertions for the external bus mode sequencer
`timescale 1ns/100ps
module ebms_checker (
  input wire sys_clk,
  input wire rst_n,
  input wire req,
  input wire [23:0] addr_q,
  input wire data_oe_q,
  input wire [3:0] cs_n_q,
  input wire rd_n_q,
  input wire wr_n_q,
  input wire memory_request_strobe_n_q,
  input wire io_request_strobe_n_q,
  input wire ale_q,
  input wire busy_q,
  input wire done_q
);
  // One clock domain, so one default clock and reset
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_done_idle: assert property (done_q |-> cs_n_q == 4'hF && rd_n_q && wr_n_q)
    else $error("strobe left active at cycle end");
  a_rd_wr_excl: assert property (rd_n_q || wr_n_q)
    else $error("read and write strobes together");
  a_req_excl: assert property (memory_request_strobe_n_q || io_request_strobe_n_q)
    else $error("both request strobes low");
  a_strobe_sel: assert property (!(rd_n_q && wr_n_q) |-> cs_n_q != 4'hF)
    else $error("strobe without chip select");
  a_ale_pulse: assert property ($rose(ale_q) |-> ##[1:7] !ale_q)
    else $error("latch strobe held too long");
  a_accept_start: assert property (req && !busy_q |=> busy_q && cs_n_q != 4'hF)
    else $error("request not started");
  a_addr_stable: assert property (busy_q && $past(busy_q) |-> $stable(addr_q))
    else $error("address moved in a cycle");
  a_read_float: assert property (!rd_n_q |-> !data_oe_q)
    else $error("data driven during read");
endmodule // ebms_checker
bind ebms_sequencer ebms_checker chk_i (.sys_clk, .rst_n, .req, .addr_q, .data_oe_q, .cs_n_q,
  .rd_n_q, .wr_n_q, .memory_request_strobe_n_q, .io_request_strobe_n_q, .ale_q, .busy_q, .done_q);

/* verification/ebms_periph.sv */
// Behavioural peripheral answering the sequencer's bus cycles
`timescale 1ns/100ps
module ebms_periph (
  input wire sys_clk,
  input wire cs_n,
  input wire rd_n,
  input wire [7:0] stall,
  input wire [7:0] rdat,
  output logic wait_n,
  output logic [7:0] data_in
);
  logic [7:0] cnt_q;
  // Known levels before the first edge
  initial begin
    wait_n = 1'h1;
    data_in = 8'h00;
    cnt_q = 8'h00;
  end
  // Wait held low a set number of clocks into each selected cycle
  always @(posedge sys_clk) begin
    cnt_q <= cs_n ? 8'h00 : cnt_q + 8'h01;
    wait_n <= cs_n || cnt_q >= stall;
    // Released lines toggle so a stale byte cannot pass for read data
    data_in <= (!cs_n && !rd_n) ? rdat : ~data_in;
  end
endmodule // ebms_periph

/* verification/tb_top.sv */
// Self-checking bench for the external bus mode sequencer
`timescale 1ns/100ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin fail_count++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module tb_top;
  logic sys_clk, rst_n, req, req_write, req_io, wait_n;
  logic [1:0] req_cs;
  logic [23:0] req_addr, addr_q;
  logic [7:0] req_wdata, data_in, data_out_q, rdata_q, stall, rdat;
  logic [3:0] cfg_mode, cfg_mux, cs_n_q;
  logic [15:0] cfg_clks;
  logic data_oe_q, rd_n_q, wr_n_q, mem_rq_n, io_rq_n, ale_q, busy_q, done_q;
  int fail_count = 0, compares = 0, cycles = 0;
  ebms_sequencer ebms_sequencer_i (.sys_clk, .rst_n, .req, .req_cs, .req_write, .req_io,
    .req_addr, .req_wdata, .cfg_mode, .cfg_mux, .cfg_clks, .wait_n, .data_in, .addr_q,
    .data_out_q, .data_oe_q, .cs_n_q, .rd_n_q, .wr_n_q, .memory_request_strobe_n_q(mem_rq_n),
    .io_request_strobe_n_q(io_rq_n), .ale_q, .busy_q, .done_q, .rdata_q);
  ebms_periph ebms_periph_i (.sys_clk, .cs_n(&cs_n_q), .rd_n(rd_n_q), .stall, .rdat, .wait_n,
    .data_in);
  // 100 MHz clock
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  task end_sim;
    if (fail_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard, far above the few hundred clocks the run needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      end_sim;
    end
  end
  // One bus cycle, every clock compared against the state walk
  task automatic run(input int c, w, io, four, mux, len, stl, nw, input logic [7:0] rv);
    int e, k, l;
    logic m, act, t2, rq;
    logic [3:0] st_e;
    cfg_mode[c] = four[0];
    cfg_mux[c] = mux[0];
    cfg_clks[4*c+:4] = len[3:0];
    stall = stl[7:0];
    rdat = rv;
    req_cs = c[1:0];
    req_write = w[0];
    req_io = io[0];
    req_addr = {16'hC35A, rv ^ 8'h3C};
    req_wdata = ~rv;
    req = 1'h1;
    @(negedge sys_clk);
    req = 1'h0;
    // Lengths below a mode's minimum run at that minimum
    l = (four && len < 2) ? 2 : ((len < 1) ? 1 : len);
    e = ((four ? 4 : 3) + nw) * l;
    m = mux[0] & four[0];
    for (k = 0; k <= e; k++) begin
      act = k < e;
      t2 = k >= l && k < (four ? e - l : e);
      rq = k >= l && act;
      st_e = {!(t2 && !w), !(t2 && w), !(rq && !io), !(rq && io)};
      `CHK("select", act ? ~(4'h1 << c) : 4'hF, cs_n_q)
      `CHK("addr", req_addr, addr_q)
      `CHK("strobes", st_e, {rd_n_q, wr_n_q, mem_rq_n, io_rq_n})
      `CHK("latch", four[0] && k < l / 2, ale_q)
      `CHK("drive", act && (m ? (k < l || w) : w), data_oe_q)
      if (data_oe_q === 1'h1)
        `CHK("data", (m && k < l) ? req_addr[7:0] : req_wdata, data_out_q)
      `CHK("busy", act, busy_q)
      `CHK("done", k == e, done_q)
      @(negedge sys_clk);
    end
    if (!w) `CHK("rdata", rv, rdata_q)
  endtask
  // Three-state writes at the shortest and longest state
  task t_three_write;
    run(0, 1, 0, 0, 0, 1, 0, 0, 8'h00);
    run(1, 1, 1, 0, 1, 15, 0, 0, 8'hFF);
  endtask
  // Three-state reads, one stretched by two wait states
  task t_three_read;
    run(2, 0, 1, 0, 0, 4, 11, 2, 8'h96);
    run(3, 0, 0, 0, 0, 2, 0, 0, 8'h5A);
  endtask
  // Four-state separate buses at both length bounds
  task t_four_sep;
    run(1, 0, 0, 1, 0, 2, 0, 0, 8'hC3);
    run(2, 1, 1, 1, 0, 15, 0, 0, 8'h3C);
  endtask
  // Four-state multiplexed with ready low for two states
  task t_four_mux;
    run(3, 0, 1, 1, 1, 4, 11, 2, 8'hA5);
    run(0, 1, 0, 1, 1, 4, 11, 2, 8'h69);
  endtask
  // Out-of-range state lengths fall back to each mode's minimum
  task t_len_clamp;
    run(0, 1, 0, 0, 0, 0, 0, 0, 8'h1E);
    run(2, 0, 0, 1, 1, 1, 0, 0, 8'h77);
  endtask
  // Reset, then every scenario back to back
  initial begin
    rst_n = 1'h0;
    req = 1'h0;
    {req_cs, req_write, req_io, req_addr, req_wdata} = 36'h0;
    {cfg_mode, cfg_mux, cfg_clks, stall, rdat} = 40'h0;
    repeat (6) @(negedge sys_clk);
    rst_n = 1'h1;
    repeat (3) @(negedge sys_clk);
    t_three_write;
    t_three_read;
    t_four_sep;
    t_four_mux;
    t_len_clamp;
    end_sim;
  end
endmodule // tb_top
